// >>> common/daq_pkg.sv
// Shared constants and types for the pacer, timer and interrupt block
package daq_pkg;

  // ==========================================================================
  // Clocking
  // ==========================================================================
  localparam int unsigned PCLK_HZ   = 125_000_000;
  localparam int unsigned TIMER_HZ  = 5_000_000;
  localparam int unsigned TIMER_DIV = PCLK_HZ / TIMER_HZ;
  localparam logic [4:0]  TDIV_LAST = 5'(TIMER_DIV - 1);

  // ==========================================================================
  // Register byte addresses
  // ==========================================================================
  localparam logic [7:0] A_PORT0     = 8'h00;
  localparam logic [7:0] A_PORT1     = 8'h04;
  localparam logic [7:0] A_PORT2     = 8'h08;
  localparam logic [7:0] A_TMR_CTRL  = 8'h0C;
  localparam logic [7:0] A_GC_CFG    = 8'h10;
  localparam logic [7:0] A_IRQ_SRC   = 8'h14;
  localparam logic [7:0] A_IRQ_STAT  = 8'h18;
  localparam logic [7:0] A_IRQ_EN    = 8'h1C;
  localparam logic [7:0] A_IRQ_CLR   = 8'h20;
  localparam logic [7:0] A_FIFO_STAT = 8'h24;
  localparam logic [7:0] A_FIFO_CTRL = 8'h28;
  localparam logic [7:0] A_DATA16    = 8'h2C;
  localparam logic [7:0] A_DATA32    = 8'h30;

  // ==========================================================================
  // Field positions, encodings, sizes
  // ==========================================================================
  localparam int unsigned ST_CONV    = 0;
  localparam int unsigned ST_TIMING  = 1;
  localparam int unsigned ST_OVERRUN = 2;
  localparam logic [1:0]  SRC_OFF    = 2'h0;
  localparam logic [1:0]  SRC_ONE    = 2'h1;
  localparam logic [1:0]  SRC_TWO    = 2'h2;
  localparam logic [2:0]  MODE_ONESHOT = 3'h1;
  localparam logic [2:0]  MODE_RATE    = 3'h2;
  localparam int unsigned FIFO_DEPTH = 1024;
  localparam int unsigned FIFO_AW    = 10;
  localparam logic [10:0] FIFO_HALF  = 11'h200;
  localparam logic [10:0] FIFO_FULL  = 11'h400;

  typedef struct packed {
    logic [4:0]  chan;
    logic [11:0] data;
  } sample_s;

  typedef struct packed {
    logic [1:0] rw;
    logic [2:0] mode;
  } ctrl_word_s;

  typedef enum logic [1:0] {
    AP_IDLE = 2'b01,
    AP_DONE = 2'b10
  } apb_phase_e;

endpackage

// >>> src/pit_channel.sv
// One programmable interval timer channel with byte-wide port access
`timescale 1ns/1ps
module pit_channel (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 tick,
  input  wire logic                 gate,
  input  wire logic                 fixed_rate,
  input  wire logic                 cw_wr,
  input  wire daq_pkg::ctrl_word_s  cw,
  input  wire logic                 port_wr,
  input  wire logic                 port_rd,
  input  wire logic [7:0]           din,
  output logic      [7:0]           dout,
  output logic                      out
);

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] init;
    logic [15:0] latch;
    logic [7:0]  stage;
    logic [1:0]  rw;
    logic [2:0]  mode;
    logic        wmsb;
    logic        rmsb;
    logic        latched;
    logic        run;
    logic        out;
    logic        gate_q;
  } pit_s;

  pit_s q, d;

  // Codes 6 and 7 alias the rate and square-wave modes
  function automatic logic [2:0] eff_mode(input logic [2:0] m);
    eff_mode = (m[2:1] == 2'b11) ? {1'b0, m[1:0]} : m;
  endfunction

  logic [2:0]  m;
  logic [15:0] nv;
  logic        load;
  logic [15:0] v;

  always_comb begin
    d    = q;
    load = 1'b0;
    nv   = q.init;
    m    = fixed_rate ? daq_pkg::MODE_RATE : eff_mode(q.mode);
    d.gate_q = gate;
    if (cw_wr) begin
      if (cw.rw == 2'h0) begin
        d.latch   = q.cnt;
        d.latched = 1'b1;
      end else begin
        d.rw   = cw.rw;
        d.mode = cw.mode;
        d.wmsb = 1'b0;
        d.rmsb = 1'b0;
        d.run  = 1'b0;
        d.out  = (cw.mode != 3'h0);
      end
    end
    if (port_wr) begin
      case (q.rw)
        2'h1: begin
          nv   = {8'h00, din};
          load = 1'b1;
        end
        2'h2: begin
          nv   = {din, 8'h00};
          load = 1'b1;
        end
        default: begin
          if (!q.wmsb) begin
            d.stage = din;
            d.wmsb  = 1'b1;
          end else begin
            nv     = {din, q.stage};
            load   = 1'b1;
            d.wmsb = 1'b0;
          end
        end
      endcase
    end
    if (port_rd) begin
      if (q.rw == 2'h3) d.rmsb = ~q.rmsb;
      if (q.rw != 2'h3 || q.rmsb) d.latched = 1'b0;
    end
    if (load) begin
      d.init = nv;
      d.cnt  = nv;
      if (nv == 16'h0000) begin
        d.run = 1'b0;
        d.out = 1'b1;
      end else begin
        d.run = (m != 3'h1) && (m != 3'h5);
        d.out = (m != 3'h0);
      end
    end else if (gate && !q.gate_q && q.init != 16'h0000 && m != 3'h0 && m != 3'h4) begin
      d.cnt = q.init;
      d.run = 1'b1;
      d.out = (m != 3'h1);
    end else if (tick && q.run && (gate || m == 3'h1 || m == 3'h5)) begin
      case (m)
        3'h0, 3'h1: begin
          d.cnt = q.cnt - 16'h0001;
          if (q.cnt == 16'h0001) begin
            d.out = 1'b1;
            d.run = 1'b0;
          end
        end
        3'h2: begin
          if (q.cnt == 16'h0001) begin
            d.cnt = q.init;
            d.out = 1'b1;
          end else begin
            d.cnt = q.cnt - 16'h0001;
            d.out = (q.cnt != 16'h0002);
          end
        end
        3'h3: begin
          if (q.cnt <= 16'h0002) begin
            d.cnt = q.init;
            d.out = ~q.out;
          end else begin
            d.cnt = q.cnt - 16'h0002;
          end
        end
        default: begin
          if (q.cnt == 16'h0000) begin
            d.out = 1'b1;
            d.run = 1'b0;
          end else begin
            d.cnt = q.cnt - 16'h0001;
            d.out = (q.cnt != 16'h0001);
          end
        end
      endcase
    end
  end

  always_comb begin
    v    = q.latched ? q.latch : q.cnt;
    dout = (q.rw == 2'h2 || (q.rw == 2'h3 && q.rmsb)) ? v[15:8] : v[7:0];
  end

  assign out = q.out;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q      <= '0;
      q.rw   <= 2'h3;
      q.out  <= 1'b1;
      q.gate_q <= 1'b1;
    end else begin
      q <= d;
    end
  end

endmodule // pit_channel

// >>> src/sample_fifo.sv
// Conversion sample FIFO held in flip-flops
`timescale 1ns/1ps
module sample_fifo (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              clear,
  input  wire logic              push,
  input  wire daq_pkg::sample_s  wdata,
  input  wire logic              pop,
  output daq_pkg::sample_s       rdata,
  output logic      [10:0]       level
);

  typedef struct packed {
    logic [daq_pkg::FIFO_DEPTH-1:0][16:0] mem;
    logic [daq_pkg::FIFO_AW-1:0]          wp;
    logic [daq_pkg::FIFO_AW-1:0]          rp;
    logic [10:0]                          lvl;
  } fifo_s;

  fifo_s q, d;
  logic  do_push;
  logic  do_pop;

  always_comb begin
    d       = q;
    do_push = push && (q.lvl != daq_pkg::FIFO_FULL);
    do_pop  = pop && (q.lvl != 11'h000);
    if (clear) begin
      d.wp  = '0;
      d.rp  = '0;
      d.lvl = '0;
    end else begin
      if (do_push) begin
        d.mem[q.wp] = wdata;
        d.wp        = q.wp + 10'h001;
      end
      if (do_pop) d.rp = q.rp + 10'h001;
      d.lvl = q.lvl + {10'h000, do_push} - {10'h000, do_pop};
    end
  end

  assign rdata = q.mem[q.rp];
  assign level = q.lvl;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) q <= '0;
    else q <= d;
  end

endmodule // sample_fifo

// >>> src/daq_pacer_timer_interrupt.sv
// Pacer, general counter, dual interrupt lines and sample FIFO behind APB

`timescale 1ns/1ps
module daq_pacer_timer_interrupt (
  // Clock, reset, APB
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,

  // Converter side
  input  wire logic              conv_done,
  input  wire daq_pkg::sample_s  conv_sample,
  input  wire logic              converter_busy_flag,

  // Asynchronous pins
  input  wire logic              ext_irq_pin,
  input  wire logic              gc_clk_pin,
  input  wire logic              gc_gate_pin,

  // Registered outputs
  output logic                   pacer_trig,
  output logic                   gc_out,
  output logic                   conversion_irq_line,
  output logic                   timing_irq_line,
  output logic                   irq
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    // Bus answer
    daq_pkg::apb_phase_e ph;
    logic                pready;
    logic [31:0]         prdata;
    logic                pslverr;
    logic                rd_empty;

    // Pin synchronisers
    logic [2:0]          xclk;
    logic [2:0]          xirq;
    logic [1:0]          xgate;

    // Timer base
    logic [4:0]          tdiv;
    logic                base_tick;
    logic                gc_ext;

    // Interrupt state
    logic [1:0]          csel;
    logic [1:0]          tsel;
    logic [2:0]          pend;
    logic [2:0]          en;

    // Edge history
    logic                half_prev;
    logic                p1_prev;
    logic                p2_prev;

    // Outputs
    logic                pacer_trig;
    logic                irq1;
    logic                irq2;
    logic                irq;
  } top_s;

  top_s q, d;

  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  // Offsets that answer without error
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      daq_pkg::A_PORT0, daq_pkg::A_PORT1, daq_pkg::A_PORT2, daq_pkg::A_TMR_CTRL,
      daq_pkg::A_GC_CFG, daq_pkg::A_IRQ_SRC, daq_pkg::A_IRQ_STAT, daq_pkg::A_IRQ_EN,
      daq_pkg::A_IRQ_CLR, daq_pkg::A_FIFO_STAT, daq_pkg::A_FIFO_CTRL,
      daq_pkg::A_DATA16, daq_pkg::A_DATA32: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // Irq source select decode shared by both lines
  function automatic logic src_event(input logic [1:0] sel, input logic ev1, input logic ev2);
    case (sel)
      daq_pkg::SRC_ONE: src_event = ev1;
      daq_pkg::SRC_TWO: src_event = ev2;
      default:          src_event = 1'b0;
    endcase
  endfunction

  // ==========================================================================
  // Bus strobes
  // ==========================================================================
  logic        access;
  logic        done;
  logic        wr_done;
  logic        rd_done;

  // Timer channels
  logic [2:0]  port_wr;
  logic [2:0]  port_rd;
  logic [2:0]  cw_wr;
  logic [7:0]  pit_dout [3];
  logic [2:0]  pit_out;
  logic [2:0]  pit_tick;
  logic        gc_gate;

  // FIFO side
  logic        data_pop;
  logic        fifo_clear;
  logic        fifo_empty;
  logic        fifo_half;
  logic        fifo_full;
  logic [10:0] fifo_level;
  daq_pkg::sample_s         fifo_head;
  daq_pkg::ctrl_word_s      cw;

  // Completion needs pready high
  assign access  = psel && penable;
  assign done    = access && q.pready;
  assign wr_done = done && pwrite;
  assign rd_done = done && !pwrite;
  assign cw      = '{rw: pwdata[5:4], mode: pwdata[3:1]};

  // Control word bits 7:6 pick a channel
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      port_wr[i] = wr_done && (paddr == 8'(4 * i));
      port_rd[i] = rd_done && (paddr == 8'(4 * i));
      cw_wr[i]   = wr_done && (paddr == daq_pkg::A_TMR_CTRL) && (pwdata[7:6] == 2'(i));
    end
  end

  // Empty capture guards against popping a sample that arrived after the read
  assign data_pop   = rd_done && !q.rd_empty &&
                      (paddr == daq_pkg::A_DATA16 || paddr == daq_pkg::A_DATA32);
  assign fifo_clear = wr_done && (paddr == daq_pkg::A_FIFO_CTRL) && pwdata[0];
  assign fifo_empty = (fifo_level == 11'h000);
  assign fifo_half  = (fifo_level >= daq_pkg::FIFO_HALF);
  // Full: samples may be lost
  assign fifo_full  = (fifo_level == daq_pkg::FIFO_FULL);

  // ==========================================================================
  // Timer channels
  // ==========================================================================
  // Channel zero: base tick or synced pin edge
  // Channel two steps on each low pulse of channel one, so periods multiply
  assign pit_tick[0] = q.gc_ext ? (q.xclk[1] && !q.xclk[2]) : q.base_tick;
  assign pit_tick[1] = q.base_tick;
  assign pit_tick[2] = q.p1_prev && !pit_out[1];
  // Only the general counter has a gate
  assign gc_gate     = q.xgate[1];

  // Zero is the general counter, one and two the pacer
  for (genvar g = 0; g < 3; g++) begin : g_pit
    pit_channel u_pit (
      .clk        (pclk),
      .rst_n      (presetn),
      .tick       (pit_tick[g]),
      .gate       ((g == 0) ? gc_gate : 1'b1),
      .fixed_rate ((g != 0) ? 1'b1 : 1'b0),
      .cw_wr      (cw_wr[g]),
      .cw         (cw),
      .port_wr    (port_wr[g]),
      .port_rd    (port_rd[g]),
      .din        (pwdata[7:0]),
      .dout       (pit_dout[g]),
      .out        (pit_out[g])
    );
  end

  // ==========================================================================
  // Sample FIFO
  // ==========================================================================
  // Pushes while full are dropped inside
  sample_fifo u_fifo (
    .clk   (pclk),
    .rst_n (presetn),
    .clear (fifo_clear),
    .push  (conv_done),
    .wdata (conv_sample),
    .pop   (data_pop),
    .rdata (fifo_head),
    .level (fifo_level)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Helpers of the next-state process
  logic [31:0] rd_mux;
  logic        ev_conv;
  logic        ev_timing;
  logic        ev_overrun;
  logic [2:0]  clr;

  always_comb begin
    d = q;

    // Pins: the first stage feeds only the second
    d.xclk  = {q.xclk[1:0], gc_clk_pin};
    d.xirq  = {q.xirq[1:0], ext_irq_pin};
    d.xgate = {q.xgate[0], gc_gate_pin};

    // Timer base tick
    if (q.tdiv == daq_pkg::TDIV_LAST) begin
      d.tdiv      = 5'h00;
      d.base_tick = 1'b1;
    end else begin
      d.tdiv      = q.tdiv + 5'h01;
      d.base_tick = 1'b0;
    end

    // Pacer trigger on channel two low pulse
    // History resets low, so reset adds no edge
    d.p1_prev    = pit_out[1];
    d.p2_prev    = pit_out[2];
    d.pacer_trig = q.p2_prev && !pit_out[2];

    // Read mux
    case (paddr)
      daq_pkg::A_PORT0:     rd_mux = {24'h000000, pit_dout[0]};
      daq_pkg::A_PORT1:     rd_mux = {24'h000000, pit_dout[1]};
      daq_pkg::A_PORT2:     rd_mux = {24'h000000, pit_dout[2]};
      daq_pkg::A_GC_CFG:    rd_mux = {31'h00000000, q.gc_ext};
      daq_pkg::A_IRQ_SRC:   rd_mux = {28'h0000000, q.tsel, q.csel};
      daq_pkg::A_IRQ_STAT:  rd_mux = {29'h00000000, q.pend};
      daq_pkg::A_IRQ_EN:    rd_mux = {29'h00000000, q.en};
      daq_pkg::A_FIFO_STAT: rd_mux = {27'h0000000, q.pend[daq_pkg::ST_OVERRUN],
                                      converter_busy_flag, fifo_full, fifo_half, fifo_empty};
      // Empty FIFO reads zero
      daq_pkg::A_DATA16:    rd_mux = fifo_empty ? 32'h00000000 : {20'h00000, fifo_head.data};
      daq_pkg::A_DATA32:    rd_mux = fifo_empty ? 32'h00000000 :
                                     {11'h000, fifo_head.chan, 4'h0, fifo_head.data};
      default:              rd_mux = 32'h00000000;
    endcase

    // APB slave: answer in the second access cycle
    case (q.ph)
      daq_pkg::AP_IDLE: begin
        if (access) begin
          d.ph       = daq_pkg::AP_DONE;
          d.pready   = 1'b1;
          d.prdata   = pwrite ? 32'h00000000 : rd_mux;
          // Unmapped: error, write ignored
          d.pslverr  = !is_mapped(paddr);
          // No pop if empty at this cycle
          d.rd_empty = fifo_empty;
        end
      end
      daq_pkg::AP_DONE: begin
        d.ph      = daq_pkg::AP_IDLE;
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
      end
      // Stray phase codes recover to idle
      default: begin
        d.ph     = daq_pkg::AP_IDLE;
        d.pready = 1'b0;
      end
    endcase

    // Control writes
    if (wr_done) begin
      case (paddr)
        daq_pkg::A_GC_CFG:  d.gc_ext = pwdata[0];
        daq_pkg::A_IRQ_SRC: begin
          d.csel = pwdata[1:0];
          d.tsel = pwdata[3:2];
        end
        daq_pkg::A_IRQ_EN:  d.en = pwdata[2:0];
        // Read-only offsets ignore writes
        default: ;
      endcase
    end

    // Interrupt events
    d.half_prev = fifo_half;
    ev_conv    = src_event(q.csel, conv_done, fifo_half && !q.half_prev);
    ev_timing  = src_event(q.tsel, q.pacer_trig, q.xirq[1] && !q.xirq[2]);
    // A push into a full FIFO is lost
    ev_overrun = conv_done && fifo_full;
    clr = (wr_done && paddr == daq_pkg::A_IRQ_CLR) ? pwdata[2:0] : 3'h0;
    // Flush forgets the overrun
    if (fifo_clear) clr[daq_pkg::ST_OVERRUN] = 1'b1;

    // Sticky until cleared; a fresh event beats a simultaneous clear
    d.pend = (q.pend & ~clr) | {ev_overrun, ev_timing, ev_conv};

    // From next state, so a clear drops them at once
    d.irq1 = d.pend[daq_pkg::ST_CONV] && d.en[daq_pkg::ST_CONV];
    d.irq2 = d.pend[daq_pkg::ST_TIMING] && d.en[daq_pkg::ST_TIMING];
    // Overrun reaches only the combined line
    d.irq  = |(d.pend & d.en);
  end

  // ==========================================================================
  // Outputs and registers
  // ==========================================================================
  // All outputs leave flops
  assign pready              = q.pready;
  assign prdata              = q.prdata;
  assign pslverr             = q.pslverr;
  assign pacer_trig          = q.pacer_trig;
  assign gc_out              = pit_out[0];
  assign conversion_irq_line = q.irq1;
  assign timing_irq_line     = q.irq2;
  assign irq                 = q.irq;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q    <= '0;
      q.ph <= daq_pkg::AP_IDLE;
      // Gate history starts at its pin's idle level
      q.xgate <= 2'h3;
    end else begin
      q <= d;
    end
  end

endmodule // daq_pacer_timer_interrupt

// >>> testbench/daq_properties.sv
// Port-level properties of the pacer, timer and interrupt block
`timescale 1ns/1ps
module daq_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pacer_trig,
  input wire logic        gc_out,
  input wire logic        conversion_irq_line,
  input wire logic        timing_irq_line,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ========
  // Clear or enable writes are the only legal ways a line may drop
  wire clr_now = psel && penable && pready && pwrite &&
                 (paddr == daq_pkg::A_IRQ_CLR || paddr == daq_pkg::A_IRQ_EN);
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_quiet;
    !pacer_trig [*8];
  endsequence
  a_ready_wait: assert property (s_wait |=> pready) else $error("late pready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("long pready");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_trig_gap: assert property (pacer_trig |=> s_quiet) else $error("trigger too close");
  a_irq_or: assert property (conversion_irq_line || timing_irq_line |-> irq) else $error("irq mix");
  a_gc_reset: assert property ($rose(presetn) |-> gc_out) else $error("gc_out low");
  a_conv_hold: assert property (conversion_irq_line && !clr_now && !$past(clr_now) |=> conversion_irq_line)
    else $error("conv line dropped");
  a_time_hold: assert property (timing_irq_line && !clr_now && !$past(clr_now) |=> timing_irq_line)
    else $error("timing line dropped");
  c_trig: cover property (pacer_trig);
endmodule // daq_checker
bind daq_pacer_timer_interrupt daq_checker daq_checker_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pready, .pslverr, .pacer_trig, .gc_out, .conversion_irq_line, .timing_irq_line, .irq);

// >>> testbench/conv_model.sv
// Converter front end model answering start requests with samples
`timescale 1ns/1ps
module conv_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  output logic             conv_done,
  output daq_pkg::sample_s conv_sample,
  output logic             busy
);
  daq_pkg::sample_s sent[$];
  daq_pkg::sample_s smp;
  logic [1:0]       cnt_q;
  // ========
  // Sample lines toggle between results so stale data never looks valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_done <= 1'b0;
      busy <= 1'b0;
      cnt_q <= 2'h0;
      conv_sample <= '0;
    end else begin
      conv_done <= 1'b0;
      conv_sample <= ~conv_sample;
      if (start && !busy) begin
        busy <= 1'b1;
        cnt_q <= 2'h3;
      end else if (busy && cnt_q != 2'h0) begin
        cnt_q <= cnt_q - 2'h1;
      end else if (busy) begin
        smp = 17'($urandom);
        busy <= 1'b0;
        conv_done <= 1'b1;
        conv_sample <= smp;
        sent.push_back(smp);
      end
    end
  end
endmodule // conv_model

// >>> testbench/daq_pacer_timer_interrupt_test.sv
// Self-checking bench for the pacer, timer and interrupt block
`timescale 1ns/1ps
module daq_pacer_timer_interrupt_test;
  logic             pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
  logic             ext_irq_pin = 0, gc_clk_pin = 0, gc_gate_pin = 1;
  logic [7:0]       paddr = '0;
  logic [31:0]      pwdata = '0, prdata;
  logic             pready, pslverr, conv_done, busy, pacer_trig, gc_out, conversion_irq_line, timing_irq_line, irq;
  daq_pkg::sample_s conv_sample, s;
  logic [32:0]      expq[$];
  int               err_total = 0, comparisons = 0, cyc = 0, n;
  always #4 pclk = ~pclk;
  daq_pacer_timer_interrupt daq_pacer_timer_interrupt_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .conv_done, .conv_sample, .converter_busy_flag(busy), .ext_irq_pin,
    .gc_clk_pin, .gc_gate_pin, .pacer_trig, .gc_out, .conversion_irq_line, .timing_irq_line, .irq);
  conv_model conv_model_inst (.pclk, .presetn, .start(go | pacer_trig), .conv_done, .conv_sample, .busy);
  // ========
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("err_total=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, '0);
  endtask
  // Upper bits are noise the timer ports must ignore
  task automatic byte_wr(input logic [7:0] a, input logic [7:0] b);
    wr(a, {24'($urandom), b});
  endtask
  task automatic fill(input int k);
    while (conv_model_inst.sent.size() < k) begin
      @(posedge pclk) go <= 1'b1;
      @(posedge pclk) go <= 1'b0;
      repeat (5) @(posedge pclk);
    end
    repeat (10) @(posedge pclk);
  endtask
  task automatic trig_wait();
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pacer_trig !== 1'b1 && n < 3000);
  endtask
  // ========
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      check({pslverr, prdata}, expq.pop_front());
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    void'($urandom(94));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(daq_pkg::A_FIFO_STAT, 33'h1);
    rd(8'hFC, 33'h1_0000_0000);
    wr(daq_pkg::A_IRQ_EN, 32'h3);
    wr(daq_pkg::A_IRQ_SRC, 32'h0);
    @(posedge pclk) ext_irq_pin <= 1'b1;
    fill(1);
    ext_irq_pin <= 1'b0;
    rd(daq_pkg::A_IRQ_STAT, 33'h0);
    wr(daq_pkg::A_IRQ_SRC, 32'h1);
    fill(2);
    check(conversion_irq_line, 1'b1);
    fill(3);
    rd(daq_pkg::A_IRQ_STAT, 33'h1);
    wr(daq_pkg::A_IRQ_CLR, 32'h1);
    repeat (3) @(posedge pclk);
    check(conversion_irq_line, 1'b0);
    for (int i = 0; i < 3; i++) begin
      s = conv_model_inst.sent.pop_front();
      if (i == 2)
        rd(daq_pkg::A_DATA16, {21'h0, s.data});
      else
        rd(daq_pkg::A_DATA32, {12'h0, s.chan, 4'h0, s.data});
    end
    rd(daq_pkg::A_FIFO_STAT, 33'h1);
    wr(daq_pkg::A_IRQ_SRC, 32'h2);
    fill(512);
    check(conversion_irq_line, 1'b1);
    rd(daq_pkg::A_FIFO_STAT, 33'h2);
    for (int i = 0; i < 512; i++) begin
      s = conv_model_inst.sent.pop_front();
      rd(daq_pkg::A_DATA16, {21'h0, s.data});
    end
    fill(1025);
    rd(daq_pkg::A_FIFO_STAT, 33'h16);
    rd(daq_pkg::A_IRQ_STAT, 33'h5);
    wr(daq_pkg::A_FIFO_CTRL, 32'h1);
    wr(daq_pkg::A_IRQ_CLR, 32'h7);
    conv_model_inst.sent.delete();
    rd(daq_pkg::A_FIFO_STAT, 33'h1);
    wr(daq_pkg::A_IRQ_SRC, 32'h8);
    @(posedge pclk) ext_irq_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    check(timing_irq_line, 1'b1);
    ext_irq_pin <= 1'b0;
    wr(daq_pkg::A_IRQ_CLR, 32'h2);
    wr(daq_pkg::A_IRQ_SRC, 32'h4);
    // Product 50 keeps the rate at 100 KHz
    byte_wr(daq_pkg::A_TMR_CTRL, 8'h74);
    byte_wr(daq_pkg::A_PORT1, 8'h05);
    byte_wr(daq_pkg::A_PORT1, 8'h00);
    byte_wr(daq_pkg::A_TMR_CTRL, 8'hB4);
    byte_wr(daq_pkg::A_PORT2, 8'h0A);
    byte_wr(daq_pkg::A_PORT2, 8'h00);
    trig_wait();
    trig_wait();
    check(n, 33'd1250);
    rd(daq_pkg::A_IRQ_STAT, 33'h2);
    byte_wr(daq_pkg::A_PORT1, 8'h00);
    byte_wr(daq_pkg::A_PORT1, 8'h00);
    repeat (1300) @(posedge pclk);
    trig_wait();
    check(n, 33'd3000);
    for (int m = 0; m < 6; m++) begin
      byte_wr(daq_pkg::A_TMR_CTRL, {2'h0, 2'h3, 3'(m), 1'b0});
      repeat (3) @(posedge pclk);
      check(gc_out, 33'(m != 0));
    end
    byte_wr(daq_pkg::A_TMR_CTRL, 8'h32);
    byte_wr(daq_pkg::A_PORT0, 8'h00);
    byte_wr(daq_pkg::A_PORT0, 8'h00);
    repeat (3) @(posedge pclk);
    check(gc_out, 1'b1);
    wr(daq_pkg::A_GC_CFG, 32'h1);
    byte_wr(daq_pkg::A_TMR_CTRL, 8'h10);
    byte_wr(daq_pkg::A_PORT0, 8'h04);
    repeat (3) @(posedge pclk);
    check(gc_out, 1'b0);
    repeat (8) begin
      gc_clk_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      gc_clk_pin <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    check(gc_out, 1'b1);
    close_out();
  end
endmodule // daq_pacer_timer_interrupt_test
